// ===== rtl/dsfe_top.sv
// Purpose: Dual speed front end selection and temperature channel routing.
// Assumes: Front-end results arrive as one-cycle strobes on the system clock.
// Notes: Registers are reached over a plain strobe port with one-cycle read data.
// Function
// - Output follows exactly one front end.
// - In dual speed the slow front end keeps bridge excitation on.
// - Large fast change switches output to fast.
// - Two quiet slow periods return to slow.
// - Percent thresholds reset to 10 and 2.
// - Any of four sources to three channels.
// - Each front end converts its own sensors.
// - Scheme picks differential or plus-only reading.
// - Dual speed allows temperature on fast only.
// - Channel one uses temperature channel one.
// - Channel two uses temperature channel two.
// - Derived channel from channels one and two.
// - Only parameter group goes to stored memory.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dsfe_top
  import dsfe_pkg::*;
#(
  parameter int QUIET = QUIET_PERIODS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [dsfe_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire dsfe_pkg::dsfe_sample_t fast_res,
  input wire dsfe_pkg::dsfe_sample_t slow_res,
  input wire dsfe_pkg::dsfe_sample_t main_two_res,
  input wire dsfe_pkg::dsfe_temp_t [dsfe_pkg::NUM_TSRC-1:0] temp_src,
  output logic bridge_bias_en,
  output logic [dsfe_pkg::NUM_TSRC-1:0] temp_conv_en,
  output dsfe_pkg::dsfe_sample_t main_channel_one,
  output logic signed [dsfe_pkg::DATA_W-1:0] main_channel_one_temp,
  output dsfe_pkg::dsfe_sample_t main_channel_two,
  output logic signed [dsfe_pkg::DATA_W-1:0] main_channel_two_temp,
  output dsfe_pkg::dsfe_sample_t derived_main_channel,
  output dsfe_pkg::dsfe_sample_t [dsfe_pkg::NUM_TCH-1:0] logical_temp_channels,
  output logic sel_fast,
  output logic [dsfe_pkg::NVM_W-1:0] nvm_param_data,
  output logic nvm_param_wr
);
  import dsfe_pkg::*;

  if (QUIET < 1 || QUIET > 15) begin : g_bad_quiet
    $error("QUIET must be 1..15");
  end

  // Control fields written by software.
  logic dual_q; // Dual speed operation selected.
  logic scheme_q; // High for differential temperature readings.
  logic [NUM_TSRC-1:0] ten_q; // Requested temperature source enables.
  logic cal1_q; // Channel one uses temperature compensation.
  logic cal2_q; // Channel two uses temperature compensation.
  logic [PCT_W-1:0] thr_entry_q; // Entry threshold in percent.
  logic [PCT_W-1:0] thr_return_q; // Return threshold in percent.
  logic [NUM_TCH*TMAP_W-1:0] tmap_q; // Source pick per logical channel.
  logic [NVM_W-1:0] nvm_q; // Parameter group mirrored to stored memory.
  dsfe_sel_t sel_q; // Which front end feeds the output.
  logic big_change; // Fast path saw a change above entry threshold.
  logic quiet_done; // Fast path quiet for the required slow periods.
  logic [NUM_TSRC-1:0] ten_eff; // Enables after dual speed limits.
  logic [31:0] rd_d; // Read mux output.

  // Decodes a write strobe for one address.
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return wr && (a == off);
  endfunction

  // Control register: mode, scheme, enables and calibration choices.
  always_ff @(posedge clk) begin
    if (rst) begin
      dual_q <= 1'b0;
      scheme_q <= 1'b0;
      ten_q <= '0;
      cal1_q <= 1'b0;
      cal2_q <= 1'b0;
    end else if (wr_hit(reg_wr, reg_addr, REG_CTRL)) begin
      dual_q <= reg_wdata[CTRL_DUAL_BIT];
      scheme_q <= reg_wdata[CTRL_SCHEME_BIT];
      ten_q <= reg_wdata[CTRL_TEN_LSB +: NUM_TSRC];
      cal1_q <= reg_wdata[CTRL_CAL1_BIT];
      cal2_q <= reg_wdata[CTRL_CAL2_BIT];
    end
  end

  // Threshold register; values up to 127 percent are stored as written, without clipping.
  always_ff @(posedge clk) begin
    if (rst) begin
      thr_entry_q <= THR_ENTRY_RST;
      thr_return_q <= THR_RETURN_RST;
    end else if (wr_hit(reg_wr, reg_addr, REG_THR)) begin
      thr_entry_q <= reg_wdata[THR_ENTRY_LSB +: PCT_W];
      thr_return_q <= reg_wdata[THR_RETURN_LSB +: PCT_W];
    end
  end

  // Temperature routing register.
  always_ff @(posedge clk) begin
    if (rst) begin
      tmap_q <= TMAP_RST;
    end else if (wr_hit(reg_wr, reg_addr, REG_TMAP)) begin
      tmap_q <= reg_wdata[NUM_TCH*TMAP_W-1:0];
    end
  end

  // Only the parameter group is forwarded to stored memory; results never are.
  always_ff @(posedge clk) begin
    if (rst) begin
      nvm_q <= '0;
      nvm_param_wr <= 1'b0;
    end else begin
      nvm_param_wr <= wr_hit(reg_wr, reg_addr, REG_NVM);
      if (wr_hit(reg_wr, reg_addr, REG_NVM)) begin
        nvm_q <= reg_wdata[NVM_W-1:0];
      end
    end
  end
  assign nvm_param_data = nvm_q;

  // In dual speed the slow front end carries the bridge, so its sensors are off.
  always_comb begin
    ten_eff = ten_q;
    if (dual_q) begin
      ten_eff[TSRC_EXT_B] = 1'b0;
      ten_eff[TSRC_EXT_C] = 1'b0;
    end
  end
  assign temp_conv_en = ten_eff;

  // Excitation held on without gaps from the cycle after dual speed is selected.
  always_ff @(posedge clk) begin
    if (rst) begin
      bridge_bias_en <= 1'b0;
    end else begin
      bridge_bias_en <= dual_q;
    end
  end

  dsfe_change_det #(
    .QUIET(QUIET)
  ) u_det (
    .clk(clk),
    .rst(rst),
    .fast_in(fast_res),
    .slow_done(slow_res.valid),
    .thr_entry(thr_entry_q),
    .thr_return(thr_return_q),
    .big_change(big_change),
    .quiet_done(quiet_done)
  );

  // Selector: slow is the precise default, fast follows large changes.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= SEL_SLOW;
    end else if (!dual_q) begin
      sel_q <= SEL_SLOW;
    end else begin
      unique case (sel_q)
        SEL_SLOW: begin
          if (big_change) begin
            sel_q <= SEL_FAST;
          end
        end
        SEL_FAST: begin
          if (quiet_done) begin
            sel_q <= SEL_SLOW;
          end
        end
        default: begin
          sel_q <= SEL_SLOW;
        end
      endcase
    end
  end
  assign sel_fast = (sel_q == SEL_FAST);

  // Channel one carries only the selected front end's result.
  always_ff @(posedge clk) begin
    if (rst) begin
      main_channel_one <= '0;
    end else begin
      main_channel_one.valid <= 1'b0;
      if (sel_q == SEL_FAST && fast_res.valid) begin
        main_channel_one <= fast_res;
      end else if (sel_q == SEL_SLOW && slow_res.valid) begin
        main_channel_one <= slow_res;
      end
    end
  end

  // Channel two passes its own sensor result; its data hold between results, like channel one.
  always_ff @(posedge clk) begin
    if (rst) begin
      main_channel_two <= '0;
    end else begin
      main_channel_two.valid <= main_two_res.valid;
      if (main_two_res.valid) begin
        main_channel_two.data <= main_two_res.data;
      end
    end
  end

  dsfe_temp_route u_route (
    .clk(clk),
    .rst(rst),
    .src(temp_src),
    .src_en(ten_eff),
    .scheme_diff(scheme_q),
    .tmap(tmap_q),
    .tch(logical_temp_channels)
  );

  // Compensation temperatures: zero when calibration does not need them.
  always_ff @(posedge clk) begin
    if (rst) begin
      main_channel_one_temp <= '0;
      main_channel_two_temp <= '0;
    end else begin
      main_channel_one_temp <= cal1_q ? logical_temp_channels[0].data : '0;
      main_channel_two_temp <= cal2_q ? logical_temp_channels[1].data : '0;
    end
  end

  // Derived channel is the difference of channels one and two.
  always_ff @(posedge clk) begin
    if (rst) begin
      derived_main_channel <= '0;
    end else begin
      derived_main_channel.valid <= main_channel_one.valid || main_channel_two.valid;
      derived_main_channel.data <= DATA_W'(main_channel_one.data - main_channel_two.data);
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_d = '0;
    unique case (reg_addr)
      REG_CTRL: begin
        rd_d[CTRL_DUAL_BIT] = dual_q;
        rd_d[CTRL_SCHEME_BIT] = scheme_q;
        rd_d[CTRL_TEN_LSB +: NUM_TSRC] = ten_q;
        rd_d[CTRL_CAL1_BIT] = cal1_q;
        rd_d[CTRL_CAL2_BIT] = cal2_q;
      end
      REG_THR: begin
        rd_d[THR_ENTRY_LSB +: PCT_W] = thr_entry_q;
        rd_d[THR_RETURN_LSB +: PCT_W] = thr_return_q;
      end
      REG_TMAP: rd_d[NUM_TCH*TMAP_W-1:0] = tmap_q;
      REG_STAT: begin
        rd_d[0] = sel_fast;
        rd_d[1] = bridge_bias_en;
        rd_d[CTRL_TEN_LSB +: NUM_TSRC] = ten_eff;
      end
      REG_NVM: rd_d[NVM_W-1:0] = nvm_q;
      default: rd_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_d : '0;
    end
  end

  sequence s_quiet;
    sel_q == SEL_FAST && quiet_done && dual_q;
  endsequence
  property p_return;
    @(posedge clk) disable iff (rst) s_quiet |=> sel_q == SEL_SLOW;
  endproperty
  a_return: assert property (p_return) else $error("no return to slow");
  property p_enter;
    @(posedge clk) disable iff (rst) (dual_q && sel_q == SEL_SLOW && big_change) |=> sel_q == SEL_FAST;
  endproperty
  a_enter: assert property (p_enter) else $error("no switch to fast");
  property p_one_src;
    @(posedge clk) disable iff (rst) (sel_q == SEL_SLOW && slow_res.valid) |=> main_channel_one.data == $past(slow_res.data);
  endproperty
  a_one_src: assert property (p_one_src) else $error("wrong source");
  property p_bias;
    @(posedge clk) disable iff (rst) dual_q [*2] |-> bridge_bias_en;
  endproperty
  a_bias: assert property (p_bias) else $error("bias dropped");
  property p_dual_temp;
    @(posedge clk) disable iff (rst) dual_q |-> temp_conv_en[TSRC_EXT_B] == 1'b0 && temp_conv_en[TSRC_EXT_C] == 1'b0;
  endproperty
  a_dual_temp: assert property (p_dual_temp) else $error("slow temp active");
  property p_thr_rst;
    @(posedge clk) $fell(rst) |-> thr_entry_q == THR_ENTRY_RST && thr_return_q == THR_RETURN_RST;
  endproperty
  a_thr_rst: assert property (p_thr_rst) else $error("bad threshold reset");
  property p_derived;
    @(posedge clk) disable iff (rst) 1'b1 |=> derived_main_channel.data ==
      DATA_W'($past(main_channel_one.data) - $past(main_channel_two.data));
  endproperty
  a_derived: assert property (p_derived) else $error("derived wrong");
  property p_nvm;
    @(posedge clk) disable iff (rst) nvm_param_wr |-> $past(reg_wr) && $past(reg_addr) == REG_NVM;
  endproperty
  a_nvm: assert property (p_nvm) else $error("stray store");
  sequence s_fast_take;
    sel_q == SEL_FAST && fast_res.valid;
  endsequence
  // While fast is selected, each fast result reaches channel one a cycle later.
  property p_fast_src;
    @(posedge clk) disable iff (rst) s_fast_take |=> main_channel_one.data == $past(fast_res.data);
  endproperty
  a_fast_src: assert property (p_fast_src) else $error("fast result lost");
  // A slow result arriving while fast is selected must not reach channel one.
  property p_slow_blocked;
    @(posedge clk) disable iff (rst) (sel_q == SEL_FAST && slow_res.valid && !fast_res.valid) |=>
      !main_channel_one.valid;
  endproperty
  a_slow_blocked: assert property (p_slow_blocked) else $error("unselected result passed");
  // Excitation drops once dual speed is left.
  property p_bias_off;
    @(posedge clk) disable iff (rst) !dual_q |=> !bridge_bias_en;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias left on");
  // With calibration on, each compensation temperature follows its own logical channel.
  property p_cal_one;
    @(posedge clk) disable iff (rst) (cal1_q && logical_temp_channels[0].valid) |=>
      main_channel_one_temp == $past(logical_temp_channels[0].data);
  endproperty
  a_cal_one: assert property (p_cal_one) else $error("channel one temperature wrong");
  property p_cal_two;
    @(posedge clk) disable iff (rst) (cal2_q && logical_temp_channels[1].valid) |=>
      main_channel_two_temp == $past(logical_temp_channels[1].data);
  endproperty
  a_cal_two: assert property (p_cal_two) else $error("channel two temperature wrong");
  // Channel two takes a result on its strobe and otherwise keeps its data.
  property p_ch2_take;
    @(posedge clk) disable iff (rst) main_two_res.valid |=> main_channel_two.data == $past(main_two_res.data);
  endproperty
  a_ch2_take: assert property (p_ch2_take) else $error("channel two result lost");
  property p_ch2_hold;
    @(posedge clk) disable iff (rst) !main_two_res.valid |=> $stable(main_channel_two.data);
  endproperty
  a_ch2_hold: assert property (p_ch2_hold) else $error("channel two data changed");
endmodule

// ===== rtl/dsfe_pkg.sv
// Purpose: Shared constants, types and register map for the dual speed front end selector.
// Assumes: One 40 MHz clock, synchronous active-high reset, plain register port.
// Notes: Results are signed 16-bit codes; thresholds are whole percent of full range.
package dsfe_pkg;

  // Width of one conversion result.
  localparam int DATA_W = 16;
  // Width of a percent threshold field.
  localparam int PCT_W = 7;
  // Full range of a signed result in codes (2^16).
  localparam int FULL_RANGE = 65536;
  // Percent divisor used when scaling a threshold to codes.
  localparam int PCT_DIV = 100;
  // Reset value of the entry threshold in percent.
  localparam logic [PCT_W-1:0] THR_ENTRY_RST = 7'h0A;
  // Reset value of the return threshold in percent.
  localparam logic [PCT_W-1:0] THR_RETURN_RST = 7'h02;
  // Quiet period in slow conversion periods.
  localparam int QUIET_PERIODS = 2;

  // Register address width and offsets.
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_THR = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TMAP = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_NVM = 4'h4;

  // Control register field positions.
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_SCHEME_BIT = 1;
  localparam int CTRL_TEN_LSB = 4;
  localparam int CTRL_CAL1_BIT = 8;
  localparam int CTRL_CAL2_BIT = 9;
  // Threshold register field positions.
  localparam int THR_ENTRY_LSB = 0;
  localparam int THR_RETURN_LSB = 8;
  // Temperature map: two bits per logical channel.
  localparam int TMAP_W = 2;
  localparam int NUM_TCH = 3;
  localparam int NUM_TSRC = 4;
  // Reset routing: channel n takes source n.
  localparam logic [5:0] TMAP_RST = 6'h24;
  // Width of the stored parameter group.
  localparam int NVM_W = 16;

  // Physical temperature source codes.
  typedef enum logic [1:0] {
    TSRC_ONCHIP = 2'h0,
    TSRC_EXT_A = 2'h1,
    TSRC_EXT_B = 2'h2,
    TSRC_EXT_C = 2'h3
  } dsfe_tsrc_t;

  // Selector states, one-hot.
  typedef enum logic [1:0] {
    SEL_SLOW = 2'b01,
    SEL_FAST = 2'b10
  } dsfe_sel_t;

  // One conversion result with its strobe.
  typedef struct packed {
    logic valid;
    logic signed [DATA_W-1:0] data;
  } dsfe_sample_t;

  // Temperature reading with plus and minus halves.
  typedef struct packed {
    logic valid;
    logic signed [DATA_W-1:0] pos;
    logic signed [DATA_W-1:0] neg;
  } dsfe_temp_t;

endpackage

// ===== rtl/dsfe_change_det.sv
// Purpose: Change detector on successive fast front-end results.
// Assumes: Thresholds arrive in whole percent of full range.
// Notes: The quiet count is in slow conversion periods, not clock cycles.
`timescale 1ns/1ps
module dsfe_change_det
  import dsfe_pkg::*;
#(
  parameter int QUIET = QUIET_PERIODS
) (
  input wire logic clk,
  input wire logic rst,
  input wire dsfe_pkg::dsfe_sample_t fast_in,
  input wire logic slow_done,
  input wire logic [dsfe_pkg::PCT_W-1:0] thr_entry,
  input wire logic [dsfe_pkg::PCT_W-1:0] thr_return,
  output logic big_change,
  output logic quiet_done
);
  import dsfe_pkg::*;

  if (QUIET < 1 || QUIET > 15) begin : g_bad_quiet
    $error("QUIET must be 1..15");
  end

  // Scales a percent to a code count of the full range.
  function automatic logic [DATA_W:0] pct_to_codes(input logic [PCT_W-1:0] pct);
    logic [31:0] prod;
    prod = 32'(pct) * 32'(FULL_RANGE) / 32'(PCT_DIV);
    return prod[DATA_W:0];
  endfunction

  logic signed [DATA_W-1:0] prev_q; // Last fast result.
  logic have_prev_q; // A previous result exists.
  logic [DATA_W:0] diff; // Absolute step between results.
  logic signed [DATA_W:0] step;
  logic over_ret; // Step exceeds the return threshold.
  logic [3:0] quiet_q; // Slow periods seen without a large step.

  // Absolute difference of successive results, one bit wider to avoid wrap.
  always_comb begin
    step = DATA_W'(0) + ($signed({fast_in.data[DATA_W-1], fast_in.data}) - $signed({prev_q[DATA_W-1], prev_q}));
    diff = step[DATA_W] ? (DATA_W+1)'(-step) : step;
  end

  assign big_change = fast_in.valid && have_prev_q && (diff > pct_to_codes(thr_entry));
  assign over_ret = fast_in.valid && have_prev_q && (diff > pct_to_codes(thr_return));
  assign quiet_done = (quiet_q >= 4'(QUIET));

  // Keeps the previous fast result.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
      have_prev_q <= 1'b0;
    end else if (fast_in.valid) begin
      prev_q <= fast_in.data;
      have_prev_q <= 1'b1;
    end
  end

  // Counts slow periods; a large step restarts it, so the step wins over a period end.
  always_ff @(posedge clk) begin
    if (rst) begin
      quiet_q <= '0;
    end else if (over_ret) begin
      quiet_q <= '0;
    end else if (slow_done && !quiet_done) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  property p_restart;
    @(posedge clk) disable iff (rst) over_ret |=> (quiet_q == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("quiet count not restarted");
endmodule

// ===== rtl/dsfe_temp_route.sv
// Purpose: Routes four temperature sources onto three logical channels.
// Assumes: Each source reading is registered at its strobe.
// Notes: A scheme bit picks half the plus-minus difference or the plus-only value.
`timescale 1ns/1ps
module dsfe_temp_route
  import dsfe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire dsfe_pkg::dsfe_temp_t [dsfe_pkg::NUM_TSRC-1:0] src,
  input wire logic [dsfe_pkg::NUM_TSRC-1:0] src_en,
  input wire logic scheme_diff,
  input wire logic [dsfe_pkg::NUM_TCH*dsfe_pkg::TMAP_W-1:0] tmap,
  output dsfe_pkg::dsfe_sample_t [dsfe_pkg::NUM_TCH-1:0] tch
);
  import dsfe_pkg::*;

  // Converts a reading by the selected measurement scheme.
  function automatic logic signed [DATA_W-1:0] scheme_val(input dsfe_temp_t t, input logic dif);
    logic signed [DATA_W:0] d;
    d = $signed({t.pos[DATA_W-1], t.pos}) - $signed({t.neg[DATA_W-1], t.neg});
    return dif ? d[DATA_W:1] : t.pos;
  endfunction

  // One registered output per logical channel; any source may feed any channel.
  genvar c;
  generate
    for (c = 0; c < NUM_TCH; c++) begin : g_ch
      logic [TMAP_W-1:0] pick;
      assign pick = tmap[c*TMAP_W +: TMAP_W];
      always_ff @(posedge clk) begin
        if (rst) begin
          tch[c] <= '0;
        end else begin
          tch[c].valid <= src[pick].valid && src_en[pick];
          if (src[pick].valid && src_en[pick]) begin
            tch[c].data <= scheme_val(src[pick], scheme_diff);
          end
        end
      end
    end
  endgenerate
endmodule

// ===== bench/dsfe_sensor_model.sv
// Purpose: Behavioural far side: slow and fast bridge front ends, sensor two, four temperature transducers.
// Assumes: Each result is one clock wide and driven just after a rising edge.
// Notes: Released data lines show the inverse of the last value, so stale data is never mistaken for fresh.
`timescale 1ns/1ps
module dsfe_sensor_model
  import dsfe_pkg::*;
(
  input wire logic clk,
  output dsfe_pkg::dsfe_sample_t fast_res,
  output dsfe_pkg::dsfe_sample_t slow_res,
  output dsfe_pkg::dsfe_sample_t main_two_res,
  output dsfe_pkg::dsfe_temp_t [dsfe_pkg::NUM_TSRC-1:0] temp_src
);
  // All strobes start low so nothing is taken during reset.
  initial begin
    fast_res = '0;
    slow_res = '0;
    main_two_res = '0;
    temp_src = '0;
  end

  // Drives one result strobe on the selected path, then releases it.
  task automatic send(input int path, input logic signed [DATA_W-1:0] v);
    @(posedge clk);
    if (path == 0) fast_res <= '{1'b1, v};
    if (path == 1) slow_res <= '{1'b1, v};
    if (path == 2) main_two_res <= '{1'b1, v};
    @(posedge clk);
    fast_res <= '{1'b0, ~fast_res.data};
    slow_res <= '{1'b0, ~slow_res.data};
    main_two_res <= '{1'b0, ~main_two_res.data};
  endtask

  // Slow result and sensor two result land in the same cycle.
  task automatic send_pair(input logic signed [DATA_W-1:0] s, input logic signed [DATA_W-1:0] m);
    @(posedge clk);
    slow_res <= '{1'b1, s};
    main_two_res <= '{1'b1, m};
    @(posedge clk);
    slow_res <= '{1'b0, ~s};
    main_two_res <= '{1'b0, ~m};
  endtask

  // Every transducer reports; source i gives plus 1000+100*i and minus 200.
  task automatic send_temps();
    @(posedge clk);
    for (int i = 0; i < NUM_TSRC; i++) begin
      temp_src[i] <= '{1'b1, 16'(1000 + 100 * i), 16'h00C8};
    end
    @(posedge clk);
    for (int i = 0; i < NUM_TSRC; i++) begin
      temp_src[i] <= '{1'b0, ~temp_src[i].pos, ~temp_src[i].neg};
    end
  endtask
endmodule

// ===== bench/dsfe_top_bench.sv
// Purpose: Self-checking bench for the dual speed selector and temperature routing.
// Assumes: 40 MHz clock, synchronous reset held 20 cycles, QUIET left at two slow periods.
// Notes: Step sizes stay well clear of threshold boundaries, so rounding of percent codes cannot matter.
`timescale 1ns/1ps
module dsfe_top_bench;
  import dsfe_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  dsfe_sample_t fast_res, slow_res, main_two_res, mc1, mc2, dmc;
  dsfe_temp_t [NUM_TSRC-1:0] temp_src;
  logic bridge_bias_en, sel_fast, nvm_param_wr;
  logic [NUM_TSRC-1:0] temp_conv_en;
  logic signed [DATA_W-1:0] mc1_temp, mc2_temp;
  dsfe_sample_t [NUM_TCH-1:0] tch;
  logic [NVM_W-1:0] nvm_param_data;
  logic [31:0] rd_val;
  int error_cnt = 0;
  int n_tests = 0;

  // The 25 ns clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  dsfe_sensor_model far (.clk(clk), .fast_res(fast_res), .slow_res(slow_res), .main_two_res(main_two_res),
    .temp_src(temp_src));

  dsfe_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_res(fast_res), .slow_res(slow_res),
    .main_two_res(main_two_res), .temp_src(temp_src), .bridge_bias_en(bridge_bias_en),
    .temp_conv_en(temp_conv_en), .main_channel_one(mc1), .main_channel_one_temp(mc1_temp),
    .main_channel_two(mc2), .main_channel_two_temp(mc2_temp), .derived_main_channel(dmc),
    .logical_temp_channels(tch), .sel_fast(sel_fast), .nvm_param_data(nvm_param_data),
    .nvm_param_wr(nvm_param_wr));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write cycle; register effects are visible once it returns.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One read cycle; the data stand only in the following cycle, so they are taken there.
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // Lets one edge pass and settle before looking at outputs.
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 1000 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step();
    rd(REG_THR);
    chk("thr_reset", rd_val, 32'h0000_020A);
    rd(REG_TMAP);
    chk("tmap_reset", rd_val, 32'h0000_0024);
    chk("sel_reset", sel_fast, 1'b0);
    $display("Test reset done");

    // Routing with the differential scheme and then the plus-only one, all four transducers on.
    wr(REG_CTRL, 32'h0000_00F2);
    chk("conv_en_all", temp_conv_en, 4'hF);
    wr(REG_TMAP, 32'h0000_0023);
    far.send_temps();
    #1;
    chk("tch0_diff", tch[0].data, 16'h0226);
    chk("tch1_diff", tch[1].data, 16'h0190);
    chk("tch2_diff", tch[2].data, 16'h01F4);
    wr(REG_CTRL, 32'h0000_03F0);
    far.send_temps();
    #1;
    chk("tch0_plus", tch[0].data, 16'h0514);
    step();
    chk("ch1_temp", mc1_temp, 16'h0514);
    chk("ch2_temp", mc2_temp, 16'h03E8);
    $display("Test routing done");

    // Main channels and the derived channel outside dual speed.
    far.send_pair(16'h03E8, 16'h012C);
    #1;
    chk("ch1_val", mc1.valid, 1'b1);
    chk("ch1_data", mc1.data, 16'h03E8);
    chk("ch2_data", mc2.data, 16'h012C);
    chk("ch2_val", mc2.valid, 1'b1);
    far.send_pair(16'h03E8, 16'h012C);
    repeat (3) step();
    chk("derived", dmc.data, 16'h02BC);
    chk("ch2_hold", mc2.data, 16'h012C);
    far.send(0, 16'h1388);
    #1;
    chk("fast_ignored", mc1.valid, 1'b0);
    chk("fast_kept", mc1.data, 16'h03E8);
    $display("Test channels done");

    // Dual speed: bias on, temperature only on the fast front end.
    wr(REG_CTRL, 32'h0000_00F1);
    step();
    chk("bias_on", bridge_bias_en, 1'b1);
    chk("conv_en_dual", temp_conv_en, 4'h3);
    rd(REG_STAT);
    chk("stat", rd_val, 32'h0000_0032);
    far.send_temps();
    #1;
    chk("tch1_en", tch[1].valid, 1'b1);
    chk("tch2_off", tch[2].valid, 1'b0);

    // Entry: a step of 5000 down to zero and one of 6000 stay under 10 percent, 8000 goes over.
    far.send(0, 16'h0000);
    far.send(0, 16'h1770);
    #1;
    chk("sel_small", sel_fast, 1'b0);
    far.send(0, 16'h36B0);
    #1;
    chk("sel_big", sel_fast, 1'b1);
    far.send(0, 16'h3E80);
    #1;
    chk("ch1_fast", mc1.data, 16'h3E80);
    far.send(1, 16'h0064);
    #1;
    chk("slow_ignored", mc1.valid, 1'b0);
    chk("bias_held", bridge_bias_en, 1'b1);

    // Return: a 2000-code step restarts the quiet count, a 500-code step does not.
    far.send(0, 16'h4650);
    far.send(0, 16'h4844);
    far.send(1, 16'h0000);
    #1;
    chk("sel_quiet1", sel_fast, 1'b1);
    far.send(1, 16'h0000);
    step();
    chk("sel_return", sel_fast, 1'b0);
    $display("Test dual done");

    // Threshold write, stored group, unmapped and read-only places.
    wr(REG_THR, 32'h0000_0205);
    rd(REG_THR);
    chk("thr_wr", rd_val, 32'h0000_0205);
    wr(REG_NVM, 32'h1234_ABCD);
    chk("nvm_wr", nvm_param_wr, 1'b1);
    chk("nvm_data", nvm_param_data, 16'hABCD);
    wr(REG_CTRL, 32'h0000_00F1);
    chk("nvm_quiet", nvm_param_wr, 1'b0);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF);
    chk("unmapped", rd_val, 32'h0000_0000);
    wr(REG_STAT, 32'h0000_0000);
    rd(REG_STAT);
    chk("stat_ro", rd_val, 32'h0000_0032);
    $display("Test registers done");
    give_verdict();
  end
endmodule
